// [ciu_pkg.sv]
// constants and types for the cache interface control registers
package ciu_pkg;
    // ------------------------------------------------------------
    // register addresses
    // ------------------------------------------------------------
    localparam logic [15:0] CIU_ADDR_CTL = 16'h00A0;
    localparam logic [15:0] CIU_ADDR_DIAG = 16'h00A1;
    localparam logic [15:0] CIU_ADDR_TOD = 16'h001B;
    // ------------------------------------------------------------
    // control register fields
    // ------------------------------------------------------------
    localparam int CIU_ENB_BIT = 0;
    localparam int CIU_ECC_BIT = 1;
    localparam int CIU_OE_BIT = 2;
    localparam int CIU_FHIT_BIT = 3;
    localparam int CIU_SPD_LSB = 4;
    // positions owned by the control register
    localparam logic [31:0] CIU_CTL_MASK = 32'hF000_673F;
    localparam logic [31:0] CIU_CTL_RESET = 32'h0000_0000;
    // ------------------------------------------------------------
    // diagnostic register fields
    // ------------------------------------------------------------
    localparam int CIU_SWCHK_BIT = 27;
    localparam int CIU_PMACC_LSB = 24;
    localparam int CIU_PMHIT_LSB = 21;
    localparam int CIU_ERRDIS_BIT = 15;
    localparam int CIU_RSVZ_BIT = 12;
    localparam int CIU_PACKDIS_BIT = 11;
    localparam int CIU_TODINC_BIT = 7;
    localparam int CIU_TODTEST_BIT = 6;
    localparam logic [31:0] CIU_DIAG_RESET = 32'h0000_8000;
    // ------------------------------------------------------------
    // cache speed codes and access times in cpu cycles
    // ------------------------------------------------------------
    localparam logic [1:0] CIU_SPD_2 = 2'h0;
    localparam logic [1:0] CIU_SPD_3 = 2'h1;
    localparam logic [2:0] CIU_CYC_2 = 3'h2;
    localparam logic [2:0] CIU_CYC_3 = 3'h3;
    localparam logic [2:0] CIU_CYC_4 = 3'h4;
    // ------------------------------------------------------------
    // timing
    // ------------------------------------------------------------
    localparam int CIU_CLK_NS = 8;
    localparam int CIU_TOD_TICK_NS = 10_000_000;
    localparam int CIU_TOD_TICK_CYC = CIU_TOD_TICK_NS / CIU_CLK_NS;
    localparam int CIU_PRE_W = 21;
    typedef logic [1:0] ciu_spd_t;
endpackage

// [ciu_regs.sv]
// cache interface control and diagnostic register bank
module ciu_regs
    import ciu_pkg::*;
#(
    parameter int TOD_TICK_CYC = CIU_TOD_TICK_CYC
) (
    input wire logic clk, // core clock
    input wire logic rst_b, // async reset, low
    // processor register port
    input wire logic [15:0] ipr_addr, // register address
    input wire logic ipr_wr_en, // write strobe
    input wire logic ipr_rd_en, // read strobe
    input wire logic [31:0] ipr_wdata, // write data
    output logic ipr_rd_valid, // read data valid
    output logic [31:0] ipr_rdata, // read data
    // cache request side
    input wire logic req_valid, // request present
    input wire logic req_block, // block read or write
    input wire logic tag_match, // tag compare result
    output logic tag_probe, // probe tag store
    output logic req_forward, // pass request on now
    output logic cache_hit, // hit answer
    output logic tag_par_check, // check tag parity
    // ram control
    input wire logic ram_access, // ram cycle wanted
    input wire logic ram_write, // ram cycle is a write
    output logic ram_chip_en, // ram chip enable
    output logic [2:0] cache_rd_cycles, // read access time
    output logic [2:0] cache_wr_cycles, // write access time
    // protection
    output logic ecc_mode, // ecc when high
    input wire logic [7:0] gen_check_bits, // generated bits
    input wire logic [7:0] check_bit_holding_reg, // software bits
    output logic [7:0] wr_check_bits, // bits for write data
    input wire logic data_ecc_err, // ecc error seen
    input wire logic data_par_err, // parity error seen
    output logic ecc_err_report, // report ecc error
    output logic par_err_report, // report parity error
    // diagnostic controls
    output logic [2:0] perfmon_access_compare, // access compare
    output logic [2:0] perfmon_hit_compare, // hit compare
    output logic write_pack_en, // write merging allowed
    output logic [31:0] tod_count // time-of-day value
);

    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    typedef struct packed {
        logic [31:0] ctl;
        logic [31:0] diag;
        logic rd_valid;
        logic [31:0] rdata;
        logic inc;
        logic [7:0] chk;
        logic ecc_rep;
        logic par_rep;
    } ciu_state_t;

    ciu_state_t s_q;
    ciu_state_t s_d;
    ciu_tod_if tod_link ();

    // cycles for a speed code
    function automatic logic [2:0] spd_cycles(input ciu_spd_t code);
        logic [2:0] cyc;
        unique case (code)
            CIU_SPD_2: cyc = CIU_CYC_2;
            CIU_SPD_3: cyc = CIU_CYC_3;
            default: cyc = CIU_CYC_4;
        endcase
        return cyc;
    endfunction

    // ------------------------------------------------------------
    // decoded configuration
    // ------------------------------------------------------------
    logic enb;
    logic fhit;
    logic oe_mode;
    logic ecc_sel;
    logic sw_chk;
    logic err_dis;
    logic wr_ctl;
    logic wr_diag;
    logic wr_tod;
    logic [31:0] ctl_view;

    // control register bits
    assign enb = s_q.ctl[CIU_ENB_BIT];
    assign fhit = s_q.ctl[CIU_FHIT_BIT];
    assign oe_mode = s_q.ctl[CIU_OE_BIT];
    assign ecc_sel = s_q.ctl[CIU_ECC_BIT];

    // diagnostic register bits
    assign sw_chk = s_q.diag[CIU_SWCHK_BIT];
    assign err_dis = s_q.diag[CIU_ERRDIS_BIT];

    // address decode of writes
    assign wr_ctl = ipr_wr_en && (ipr_addr == CIU_ADDR_CTL);
    assign wr_diag = ipr_wr_en && (ipr_addr == CIU_ADDR_DIAG);
    assign wr_tod = ipr_wr_en && (ipr_addr == CIU_ADDR_TOD);

    // merged image; control positions from control, rest from diag
    assign ctl_view = (s_q.ctl & CIU_CTL_MASK) | (s_q.diag & ~CIU_CTL_MASK);

    // ------------------------------------------------------------
    // next state
    // ------------------------------------------------------------
    always_comb begin
        s_d = s_q;
        s_d.inc = 1'b0;
        s_d.rd_valid = ipr_rd_en;

        // register writes
        if (wr_ctl) begin
            s_d.ctl = ipr_wdata & CIU_CTL_MASK;
        end
        if (wr_diag) begin
            // bit 12 stored as written; software keeps it zero
            s_d.diag = ipr_wdata & ~CIU_CTL_MASK;
            s_d.inc = ipr_wdata[CIU_TODINC_BIT] && ipr_wdata[CIU_TODTEST_BIT];
        end

        // register reads; diag address itself is not readable
        if (ipr_rd_en) begin
            unique case (ipr_addr)
                CIU_ADDR_CTL: s_d.rdata = ~ctl_view;
                CIU_ADDR_TOD: s_d.rdata = tod_link.count;
                default: s_d.rdata = 32'h0000_0000;
            endcase
        end

        // check bits for write data
        if (!sw_chk) begin
            s_d.chk = gen_check_bits;
        end else if (ecc_sel) begin
            s_d.chk = check_bit_holding_reg;
        end else begin
            // parity mode: only the two longword parity bits used
            s_d.chk = 8'h00;
            s_d.chk[0] = check_bit_holding_reg[0];
            s_d.chk[7] = check_bit_holding_reg[7];
        end

        // error reports, gated by mode and disable
        s_d.ecc_rep = ecc_sel && data_ecc_err && !err_dis;
        s_d.par_rep = !ecc_sel && data_par_err && !err_dis;
    end

    // ------------------------------------------------------------
    // state register
    // ------------------------------------------------------------
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            s_q.ctl <= CIU_CTL_RESET;
            s_q.diag <= CIU_DIAG_RESET;
            s_q.rd_valid <= 1'b0;
            s_q.rdata <= 32'h0000_0000;
            s_q.inc <= 1'b0;
            s_q.chk <= 8'h00;
            s_q.ecc_rep <= 1'b0;
            s_q.par_rep <= 1'b0;
        end else begin
            s_q <= s_d;
        end
    end

    // ------------------------------------------------------------
    // register port outputs
    // ------------------------------------------------------------
    assign ipr_rd_valid = s_q.rd_valid;
    assign ipr_rdata = s_q.rdata;

    // ------------------------------------------------------------
    // cache request handling
    // ------------------------------------------------------------
    // probe only with the cache on; force-hit still probes
    assign tag_probe = req_valid && enb;

    // disabled cache sends the request on at once
    assign req_forward = req_valid && !enb;

    // hit: forced for block ops in force-hit mode, else from tag compare
    assign cache_hit = req_valid && enb && ((fhit && req_block) || tag_match);

    // tag parity ignored in force-hit mode
    assign tag_par_check = enb && !fhit;

    // ------------------------------------------------------------
    // ram control
    // ------------------------------------------------------------
    // chip enable held off on writes in oe mode so it can drive ram oe
    assign ram_chip_en = ram_access && !(oe_mode && ram_write);

    // access times from the speed field
    assign cache_rd_cycles = spd_cycles(s_q.ctl[CIU_SPD_LSB+:2]);
    assign cache_wr_cycles = spd_cycles(s_q.ctl[CIU_SPD_LSB+:2]);

    // ------------------------------------------------------------
    // protection
    // ------------------------------------------------------------
    assign ecc_mode = ecc_sel;
    assign wr_check_bits = s_q.chk;
    assign ecc_err_report = s_q.ecc_rep;
    assign par_err_report = s_q.par_rep;

    // ------------------------------------------------------------
    // diagnostic controls
    // ------------------------------------------------------------
    assign perfmon_access_compare = s_q.diag[CIU_PMACC_LSB+:3];
    assign perfmon_hit_compare = s_q.diag[CIU_PMHIT_LSB+:3];

    // merging off when pack disable set
    assign write_pack_en = !s_q.diag[CIU_PACKDIS_BIT];

    // ------------------------------------------------------------
    // time-of-day counter
    // ------------------------------------------------------------
    // test mode and step pulse drive the counter
    assign tod_link.test_mode = s_q.diag[CIU_TODTEST_BIT];
    assign tod_link.inc_pulse = s_q.inc;
    assign tod_link.load = wr_tod;
    assign tod_link.load_value = ipr_wdata;

    ciu_tod_counter #(
        .TICK_CYC(TOD_TICK_CYC)
    ) u_tod (
        .clk(clk),
        .rst_b(rst_b),
        .tod(tod_link)
    );

    assign tod_count = tod_link.count;

endmodule

// [ciu_regs_assertions.sv]
// concurrent checks on the cache interface control register ports
module ciu_regs_chk
    import ciu_pkg::*;
#(
    parameter int TOD_TICK_CYC = CIU_TOD_TICK_CYC
) (
    input wire logic clk, // clock
    input wire logic rst_b, // reset, low
    input wire logic [15:0] ipr_addr, // address
    input wire logic ipr_wr_en, // write strobe
    input wire logic ipr_rd_en, // read strobe
    input wire logic [31:0] ipr_wdata, // write data
    input wire logic ipr_rd_valid, // read valid
    input wire logic [31:0] ipr_rdata, // read data
    input wire logic req_valid, // request
    input wire logic req_block, // block request
    input wire logic tag_match, // tag match
    input wire logic tag_probe, // probe
    input wire logic req_forward, // forward
    input wire logic cache_hit, // hit
    input wire logic ram_access, // ram cycle
    input wire logic ram_write, // ram write
    input wire logic ram_chip_en, // chip enable
    input wire logic [2:0] cache_rd_cycles, // read time
    input wire logic [2:0] cache_wr_cycles, // write time
    input wire logic ecc_mode, // ecc mode
    input wire logic data_ecc_err, // ecc error
    input wire logic ecc_err_report, // ecc report
    input wire logic par_err_report, // parity report
    input wire logic [31:0] tod_count // time of day
);
    timeunit 1ns;
    timeprecision 1ps;
    // ------------------------------------------------------------
    // properties
    // ------------------------------------------------------------
    default clocking @(posedge clk);
    endclocking
    default disable iff (!rst_b);
    property p_probe;
        req_valid |-> tag_probe != req_forward;
    endproperty
    property p_idle;
        !req_valid |-> !(tag_probe || req_forward || cache_hit);
    endproperty
    property p_hit;
        cache_hit |-> tag_probe && (req_block || tag_match);
    endproperty
    property p_ce;
        !ram_write |-> ram_chip_en == ram_access;
    endproperty
    property p_spd;
        ipr_wr_en && ipr_addr == CIU_ADDR_CTL |=> cache_rd_cycles == cache_wr_cycles
            && cache_rd_cycles == 3'h2 + ($past(ipr_wdata[5]) ? 3'h2 : {2'h0, $past(ipr_wdata[4])});
    endproperty
    property p_rdv;
        ipr_rd_valid == $past(ipr_rd_en);
    endproperty
    property p_diag_rd;
        ipr_rd_en && ipr_addr == CIU_ADDR_DIAG |=> ipr_rdata == 32'h0000_0000;
    endproperty
    property p_ecc;
        ecc_err_report |-> $past(data_ecc_err) && $past(ecc_mode);
    endproperty
    property p_par;
        par_err_report |-> !$past(ecc_mode);
    endproperty
    property p_tod;
        ipr_wr_en && ipr_addr == CIU_ADDR_DIAG && ipr_wdata[7:6] == 2'h3
            |-> ##2 tod_count == $past(tod_count, 2) + 32'h1;
    endproperty
    a_probe: assert property (p_probe) else $error("probe and forward not exclusive");
    a_idle: assert property (p_idle) else $error("cache output without request");
    a_hit: assert property (p_hit) else $error("hit without cause");
    a_ce: assert property (p_ce) else $error("chip enable wrong on read");
    a_spd: assert property (p_spd) else $error("access time wrong for speed code");
    a_rdv: assert property (p_rdv) else $error("read valid not one cycle after read");
    a_diag_rd: assert property (p_diag_rd) else $error("diagnostic register readable");
    a_ecc: assert property (p_ecc) else $error("ecc report without cause");
    a_par: assert property (p_par) else $error("parity report in ecc mode");
    a_tod: assert property (p_tod) else $error("test step did not add one");
    c_hit: cover property (cache_hit);
    c_ecc: cover property (ecc_err_report);
    c_rd: cover property (ipr_rd_valid);
endmodule

bind ciu_regs ciu_regs_chk #(.TOD_TICK_CYC(TOD_TICK_CYC)) u_chk (.*);

// [ciu_tod_counter.sv]
// time-of-day counter with 100 hz prescaler and test stepping
module ciu_tod_counter
    import ciu_pkg::*;
#(
    parameter int TICK_CYC = CIU_TOD_TICK_CYC
) (
    input wire logic clk, // core clock
    input wire logic rst_b, // async reset, low
    ciu_tod_if.tod tod // control link
);
    typedef struct packed {
        logic [CIU_PRE_W-1:0] pre;
        logic [31:0] count;
    } ciu_tod_st_t;

    ciu_tod_st_t s_q;
    ciu_tod_st_t s_d;
    logic tick;

    // ------------------------------------------------------------
    // next state
    // ------------------------------------------------------------
    always_comb begin
        s_d = s_q;
        tick = (s_q.pre == CIU_PRE_W'(TICK_CYC - 1));
        s_d.pre = tick ? '0 : s_q.pre + 1'b1;
        if (tod.load) begin
            s_d.count = tod.load_value;
        end else if (tod.test_mode) begin
            // single step only from the diagnostic write
            if (tod.inc_pulse) begin
                s_d.count = s_q.count + 32'h0000_0001;
            end
            s_d.pre = '0;
        end else if (tick && (s_q.count != 32'h0000_0000)) begin
            s_d.count = s_q.count + 32'h0000_0001;
        end
    end

    // state register
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    assign tod.count = s_q.count;
endmodule

// [ciu_tod_if.sv]
// link between the register bank and the time-of-day counter
interface ciu_tod_if;
    logic test_mode;
    logic inc_pulse;
    logic load;
    logic [31:0] load_value;
    logic [31:0] count;
    modport ctl (output test_mode, output inc_pulse, output load, output load_value, input count);
    modport tod (input test_mode, input inc_pulse, input load, input load_value, output count);
endinterface

// [testbench.sv]
// self-checking bench for the cache interface control registers
`define CHK(a, b) begin compares++; if ((a) !== (b)) begin n_errors++; \
    $display("Error t=%0t got %h exp %h", $time, a, b); end end
module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    import ciu_pkg::*;
    localparam int TICK = 20;
    logic clk, rst_b, ipr_wr_en, ipr_rd_en, ipr_rd_valid, req_valid, req_block, tag_match;
    logic tag_probe, req_forward, cache_hit, tag_par_check, ram_access, ram_write, ram_chip_en;
    logic ecc_mode, data_ecc_err, data_par_err, ecc_err_report, par_err_report, write_pack_en;
    logic [15:0] ipr_addr;
    logic [31:0] ipr_wdata, ipr_rdata, tod_count, ctl_m, diag_m;
    logic [2:0] cache_rd_cycles, cache_wr_cycles, perfmon_access_compare, perfmon_hit_compare;
    logic [7:0] gen_check_bits, check_bit_holding_reg, wr_check_bits;
    logic [2:0] cyc [4] = '{CIU_CYC_2, CIU_CYC_3, CIU_CYC_4, CIU_CYC_4};
    int n_errors = 0;
    int compares = 0;
    ciu_regs #(.TOD_TICK_CYC(TICK)) dut (.*);
    // clock
    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end
    // ------------------------------------------------------------
    // bus and drive tasks
    // ------------------------------------------------------------
    task automatic wr(input logic [15:0] a, input logic [31:0] d);
        @(posedge clk);
        ipr_addr <= a;
        ipr_wdata <= d;
        ipr_wr_en <= 1'b1;
        @(posedge clk);
        ipr_wr_en <= 1'b0;
        if (a == CIU_ADDR_CTL) ctl_m = d & CIU_CTL_MASK;
        if (a == CIU_ADDR_DIAG) diag_m = d & ~CIU_CTL_MASK;
        #1;
    endtask
    task automatic rd(input logic [15:0] a, input logic [31:0] exp);
        @(posedge clk);
        ipr_addr <= a;
        ipr_rd_en <= 1'b1;
        @(posedge clk);
        ipr_rd_en <= 1'b0;
        #1;
        `CHK(ipr_rd_valid, 1'b1)
        `CHK(ipr_rdata, exp)
    endtask
    task automatic rctl();
        rd(CIU_ADDR_CTL, ~(ctl_m | diag_m));
    endtask
    // one clock for registered outputs to follow
    task automatic step();
        @(posedge clk);
        #1;
    endtask
    task automatic rq(input logic v, input logic b, input logic m);
        @(posedge clk);
        req_valid <= v;
        req_block <= b;
        tag_match <= m;
        #1;
    endtask
    task automatic pulse(input logic ecc);
        @(posedge clk);
        data_ecc_err <= ecc;
        data_par_err <= ~ecc;
        @(posedge clk);
        data_ecc_err <= 1'b0;
        data_par_err <= 1'b0;
        #1;
    endtask
    task automatic report_and_stop();
        $display("compares %0d errors %0d", compares, n_errors);
        if (n_errors == 0 && compares > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask
    // ------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------
    task automatic t_reset();
        `CHK(cache_rd_cycles, 3'h2)
        `CHK(write_pack_en, 1'b1)
        rctl();
        rd(CIU_ADDR_DIAG, 32'h0000_0000);
        rd(16'h0055, 32'h0000_0000);
        rq(1'b1, 1'b1, 1'b1);
        `CHK({tag_probe, req_forward, cache_hit}, 3'h2)
        $display("reset test done");
    endtask
    task automatic t_speed();
        for (int i = 0; i < 4; i++) begin
            wr(CIU_ADDR_CTL, 32'(i) << 4);
            `CHK({cache_rd_cycles, cache_wr_cycles}, {cyc[i], cyc[i]})
            rctl();
        end
        $display("speed test done");
    endtask
    task automatic t_cache();
        wr(CIU_ADDR_CTL, 32'h0000_0009);
        `CHK(tag_par_check, 1'b0)
        rq(1'b1, 1'b1, 1'b0);
        `CHK({tag_probe, req_forward, cache_hit}, 3'h5)
        rq(1'b1, 1'b0, 1'b0);
        `CHK(cache_hit, 1'b0)
        wr(CIU_ADDR_CTL, 32'h0000_0008);
        rq(1'b1, 1'b1, 1'b1);
        `CHK({tag_probe, req_forward, cache_hit}, 3'h2)
        wr(CIU_ADDR_CTL, 32'h0000_0001);
        `CHK(tag_par_check, 1'b1)
        rq(1'b1, 1'b1, 1'b0);
        `CHK({tag_probe, req_forward, cache_hit}, 3'h4)
        rq(1'b0, 1'b0, 1'b0);
        $display("cache test done");
    endtask
    task automatic t_oe();
        wr(CIU_ADDR_CTL, 32'h0000_0004);
        @(posedge clk);
        ram_access <= 1'b1;
        ram_write <= 1'b1;
        #1;
        `CHK(ram_chip_en, 1'b0)
        wr(CIU_ADDR_CTL, 32'h0000_0000);
        `CHK(ram_chip_en, 1'b1)
        @(posedge clk);
        ram_access <= 1'b0;
        $display("oe test done");
    endtask
    task automatic t_prot();
        @(posedge clk);
        gen_check_bits <= 8'h3C;
        check_bit_holding_reg <= 8'hA5;
        wr(CIU_ADDR_CTL, 32'h0000_0002);
        `CHK(ecc_mode, 1'b1)
        wr(CIU_ADDR_DIAG, 32'h0800_0000);
        step();
        `CHK(wr_check_bits, 8'hA5)
        pulse(1'b1);
        `CHK({ecc_err_report, par_err_report}, 2'h2)
        wr(CIU_ADDR_CTL, 32'h0000_0000);
        step();
        `CHK(wr_check_bits, 8'h81)
        pulse(1'b0);
        `CHK({ecc_err_report, par_err_report}, 2'h1)
        wr(CIU_ADDR_DIAG, 32'h0000_8000);
        step();
        `CHK(wr_check_bits, 8'h3C)
        pulse(1'b0);
        `CHK(par_err_report, 1'b0)
        $display("protection test done");
    endtask
    task automatic t_diag();
        wr(CIU_ADDR_DIAG, 32'h0560_8800);
        `CHK({perfmon_access_compare, perfmon_hit_compare}, 6'h2B)
        `CHK(write_pack_en, 1'b0)
        wr(CIU_ADDR_CTL, 32'hFFFF_FFFF);
        rctl();
        wr(CIU_ADDR_CTL, 32'h0000_0000);
        $display("diagnostic test done");
    endtask
    task automatic t_tod();
        wr(CIU_ADDR_DIAG, 32'h0000_8080);
        repeat (TICK + 4) @(posedge clk);
        #1;
        `CHK(tod_count, 32'h0000_0000)
        wr(CIU_ADDR_DIAG, 32'h0000_8040);
        wr(CIU_ADDR_DIAG, 32'h0000_80C0);
        wr(CIU_ADDR_DIAG, 32'h0000_80C0);
        step();
        `CHK(tod_count, 32'h0000_0002)
        wr(CIU_ADDR_TOD, 32'h0000_0010);
        rd(CIU_ADDR_TOD, 32'h0000_0010);
        wr(CIU_ADDR_DIAG, 32'h0000_8000);
        repeat (TICK + 4) @(posedge clk);
        #1;
        `CHK(tod_count, 32'h0000_0011)
        $display("time of day test done");
    endtask
    // ------------------------------------------------------------
    // main sequence and watchdog
    // ------------------------------------------------------------
    initial begin
        {rst_b, ipr_wr_en, ipr_rd_en, req_valid, req_block, tag_match} = '0;
        {ram_access, ram_write, data_ecc_err, data_par_err} = '0;
        {ipr_addr, ipr_wdata, gen_check_bits, check_bit_holding_reg} = '0;
        ctl_m = 32'h0000_0000;
        diag_m = 32'h0000_8000;
        repeat (10) @(posedge clk);
        rst_b <= 1'b1;
        t_reset();
        t_speed();
        t_cache();
        t_oe();
        t_prot();
        t_diag();
        t_tod();
        report_and_stop();
    end
    initial begin
        repeat (3000) @(posedge clk);
        n_errors++;
        report_and_stop();
    end
endmodule
